/* File: hdl/symmetric_clamp_quantizer.sv */
`timescale 1ns/1ps
module symmetric_clamp_quantizer
  import sq_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // measured quantities, per-unit, one strobe for all
  input wire logic smp_valid_i,
  input wire logic [NQTY-1:0][SMP_W-1:0] qty_i,
  // per-quantizer settings
  input wire logic [NINST-1:0][SEL_W-1:0] src_sel_i,
  input wire logic [NINST-1:0][LIM_W-1:0] limit_i,
  input wire logic [NINST-1:0][SMP_W-1:0] bypass_thr_i,
  // code stream, one per quantizer
  output logic [NINST-1:0][CODE_W-1:0] code_o,
  output logic [NINST-1:0] code_valid_o,
  input wire logic [NINST-1:0] code_ready_i,
  // status
  output logic [NINST-1:0][CODE_W-1:0] status_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // one bit wider than the value, so the most negative input still fits
  function automatic logic [SMP_W:0] mag_of(
    input logic signed [SMP_W:0] v
  );
    mag_of = v[SMP_W] ? -v : v;
  endfunction

  genvar g;
  generate
    for (g = 0; g < NINST; g++)
    begin : g_inst
      // --------------------------------------------------------------
      // per-quantizer state
      // --------------------------------------------------------------
      qstate_e st_r;
      logic signed [SMP_W-1:0] avg_r;
      logic seeded_r;
      logic [NUM_W-1:0] rem_r;
      logic [NUM_W-1:0] den_r;
      logic [CODE_W-1:0] q_r;
      logic [2:0] bit_r;
      logic neg_r;
      logic [CODE_W-1:0] head_r;
      logic head_v_r;
      logic [CODE_W-1:0] spare_r;
      logic spare_v_r;
      logic [CODE_W-1:0] status_r;

      // --------------------------------------------------------------
      // averaging
      // --------------------------------------------------------------
      // a sample is only taken while the sequencer waits for one
      wire logic accept = (st_r == S_IDLE) && smp_valid_i;
      wire logic signed [SMP_W-1:0] x = qty_i[src_sel_i[g]];
      wire logic signed [SMP_W:0] diff =
        {x[SMP_W-1], x} - {avg_r[SMP_W-1], avg_r};
      wire logic [SMP_W:0] adiff = mag_of(diff);
      // strict compare: a step equal to the threshold is still filtered
      wire logic big = adiff > {1'b0, bypass_thr_i[g]};
      // signed on both sides, else the step shift turns logical
      wire logic signed [SMP_W:0] avg_step =
        $signed({avg_r[SMP_W-1], avg_r}) + (diff >>> AVG_SHIFT);
      // first sample seeds the average; a jump drops the filter
      wire logic signed [SMP_W-1:0] avg_nxt = (big || !seeded_r) ?
        x : avg_step[SMP_W-1:0];

      always_ff @(posedge mclk_i)
      begin
        if (srst_i)
        begin
          avg_r <= AVG_RST;
          seeded_r <= 1'b0;
        end
        else if (accept)
        begin
          avg_r <= avg_nxt;
          seeded_r <= 1'b1;
        end
      end

      // --------------------------------------------------------------
      // clamp and rounding numerator
      // --------------------------------------------------------------
      // limit is per-unit on the same scale as the samples
      wire logic signed [SMP_W-1:0] lim = {1'b0, limit_i[g]};
      wire logic signed [SMP_W-1:0] clamped = (avg_nxt > lim) ? lim :
        (avg_nxt < -lim) ? -lim : avg_nxt;
      wire logic [SMP_W:0] mag_w = mag_of({clamped[SMP_W-1], clamped});
      wire logic [SMP_W-1:0] mag = mag_w[SMP_W-1:0];
      // round half away from zero: (254*|x| + L) / (2L)
      wire logic [NUM_W-1:0] num =
        NUM_W'(mag) * CODE_SCALE2 + NUM_W'(lim);
      wire logic [NUM_W-1:0] den2 = NUM_W'({lim, 1'b0});
      wire logic [NUM_W-1:0] trial = den_r << bit_r;
      wire logic take = rem_r >= trial;
      // quotient never passes 127 since |x| <= L
      wire logic [CODE_W-1:0] word =
        {neg_r && (q_r[6:0] != 7'h00), q_r[6:0]};

      // --------------------------------------------------------------
      // two-entry output buffer
      // --------------------------------------------------------------
      // head feeds the output; spare catches a word while head is stalled
      // a pop and a push in one cycle keep a fill of one; no push is taken while spare is full, so a full pair drains
      wire logic push = (st_r == S_PUSH) && !spare_v_r;
      wire logic pop = head_v_r && code_ready_i[g];
      wire logic hv_pop = pop ? spare_v_r : head_v_r;
      wire logic [CODE_W-1:0] hd_pop = (pop && spare_v_r) ? spare_r : head_r;
      wire logic sv_pop = spare_v_r && !pop;
      wire logic head_v_nxt = hv_pop || push;
      wire logic [CODE_W-1:0] head_nxt = (push && !hv_pop) ? word : hd_pop;
      wire logic spare_v_nxt = sv_pop || (push && hv_pop);
      wire logic [CODE_W-1:0] spare_nxt =
        (push && hv_pop) ? word : spare_r;

      always_ff @(posedge mclk_i)
      begin
        if (srst_i)
        begin
          head_r <= CODE_RST;
          head_v_r <= 1'b0;
          spare_r <= CODE_RST;
          spare_v_r <= 1'b0;
        end
        else
        begin
          head_r <= head_nxt;
          head_v_r <= head_v_nxt;
          spare_r <= spare_nxt;
          spare_v_r <= spare_v_nxt;
        end
      end

      // --------------------------------------------------------------
      // sequencer: sample, 8-step division, hand-off
      // --------------------------------------------------------------
      // samples arriving while busy are skipped, not queued
      // one quotient bit per edge: 8 cycles traded for a small divider
      always_ff @(posedge mclk_i)
      begin
        if (srst_i)
        begin
          st_r <= S_IDLE;
          rem_r <= '0;
          den_r <= '0;
          q_r <= CODE_RST;
          bit_r <= 3'h0;
          neg_r <= 1'b0;
        end
        else
        begin
          unique case (st_r)
            S_IDLE:
            begin
              if (smp_valid_i)
              begin
                neg_r <= clamped[SMP_W-1];
                rem_r <= num;
                den_r <= den2;
                q_r <= CODE_RST;
                bit_r <= 3'(QBIT_TOP);
                // zero limit has no scale; emit zero
                st_r <= (lim == '0) ? S_PUSH : S_DIV;
              end
            end
            S_DIV:
            begin
              if (take)
              begin
                rem_r <= rem_r - trial;
                q_r[bit_r] <= 1'b1;
              end
              if (bit_r == 3'h0)
                st_r <= S_PUSH;
              else
                bit_r <= bit_r - 3'h1;
            end
            S_PUSH:
            begin
              // full buffer stalls here, so no word is lost
              if (push)
                st_r <= S_IDLE;
            end
          endcase
        end
      end

      // status follows every word into the buffer, held until the next
      always_ff @(posedge mclk_i)
      begin
        if (srst_i)
          status_r <= CODE_RST;
        else if (push)
          status_r <= word;
      end

      // --------------------------------------------------------------
      // outputs, all straight from registers
      // --------------------------------------------------------------
      assign code_o[g] = head_r;
      assign code_valid_o[g] = head_v_r;
      assign status_o[g] = status_r;
    end
  endgenerate

endmodule

/* File: hdl/sq_pkg.sv */
package sq_pkg;
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NINST = 5;
  localparam int NQTY = 4;
  localparam int SEL_W = 2;
  localparam int SMP_W = 16;
  localparam int LIM_W = 15;
  localparam int CODE_W = 8;
  localparam int NUM_W = 24;
  // ----------------------------------------------------------------
  // field positions and scaling
  // ----------------------------------------------------------------
  localparam int SIGN_POS = 7;
  localparam int QBIT_TOP = 7;
  localparam logic [NUM_W-1:0] CODE_SCALE2 = 24'h0000FE;
  localparam int AVG_SHIFT = 2;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [CODE_W-1:0] CODE_RST = 8'h00;
  localparam logic [SMP_W-1:0] AVG_RST = 16'h0000;
  typedef enum logic [1:0] {S_IDLE, S_DIV, S_PUSH} qstate_e;
endpackage

/* File: sim/symmetric_clamp_quantizer_assertions.sv */
`timescale 1ns/1ps
module sq_assertions
  import sq_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // block ports
  input wire logic smp_valid_i,
  input wire logic [NINST-1:0][LIM_W-1:0] limit_i,
  input wire logic [NINST-1:0][CODE_W-1:0] code_o,
  input wire logic [NINST-1:0] code_valid_o,
  input wire logic [NINST-1:0] code_ready_i,
  input wire logic [NINST-1:0][CODE_W-1:0] status_o
);
  // quantizer 0 only except the reset check, the others share its logic
  wire v = code_valid_o[0];
  wire [7:0] c = code_o[0];
  wire z = limit_i[0] == 15'h0000;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  sequence s_take;
    smp_valid_i && !v;
  endsequence
  sequence s_busy;
    !v [*8] ##1 !v;
  endsequence
  a_on_time: assert property (s_take ##0 !z |=> s_busy ##1 v)
    else $error("word late");
  a_zero_lim: assert property (s_take ##0 z |=> ##1 v && c == 8'h00)
    else $error("zero limit word");
  a_stall_hold: assert property (v && !code_ready_i[0] |=> v && $stable(c))
    else $error("word lost in stall");
  a_no_negzero: assert property (v |-> c != 8'h80)
    else $error("negative zero");
  a_status_push: assert property ($rose(v) |-> status_o[0] == c)
    else $error("status differs");
  a_rise_cause: assert property ($rose(v) |->
    $past(smp_valid_i, 10) || $past(smp_valid_i, 2))
    else $error("word without sample");
  a_status_when: assert property ($changed(status_o[0]) |->
    $past(smp_valid_i, 10) || $past(smp_valid_i, 2))
    else $error("status moved alone");
  a_reset_clr: assert property (disable iff (1'b0)
    srst_i |=> code_valid_o == 5'h00 && status_o == '0)
    else $error("reset not clear");
endmodule
bind symmetric_clamp_quantizer sq_assertions u_chk (.*);

/* File: sim/code_sink.sv */
`timescale 1ns/1ps
module code_sink
  import sq_pkg::*;
(
  // control
  input wire logic stall_i,
  // ready to the block
  output logic [NINST-1:0] code_ready_o
);
  assign code_ready_o = {NINST{!stall_i}};
endmodule

/* File: sim/test_symmetric_clamp_quantizer.sv */
`timescale 1ns/1ps
module test_symmetric_clamp_quantizer
  import sq_pkg::*;
;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic smp_valid_i = 1'b0;
  logic stall = 1'b0;
  logic [NQTY-1:0][SMP_W-1:0] qty_i = '0;
  logic [NINST-1:0][SEL_W-1:0] src_sel_i = {2'h0, 2'h3, 2'h2, 2'h1, 2'h0};
  logic [NINST-1:0][LIM_W-1:0] limit_i =
    {15'h012C, 15'h00FE, 15'h007F, 15'h03E8, 15'h07D0};
  logic [NINST-1:0][SMP_W-1:0] bypass_thr_i = '0;
  logic [NINST-1:0][CODE_W-1:0] code_o, status_o, e, head;
  logic [NINST-1:0] code_valid_o, code_ready_i;
  int num_errors = 0;
  int n_checks = 0;
  int avg [NINST];
  initial forever #5 mclk_i = ~mclk_i;
  symmetric_clamp_quantizer u_dut (.*);
  code_sink u_sink (.stall_i(stall), .code_ready_o(code_ready_i));
  task chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1)
    begin
      num_errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  function automatic logic [7:0] quant(int x, int l);
    int t, m;
    t = x > l ? l : (x < -l ? -l : x);
    m = l == 0 ? 0 : ((t < 0 ? -t : t) * 254 + l) / (2 * l);
    return {t < 0 && m != 0, m[6:0]};
  endfunction
  // thr 0 in the first scenario seeds every average with the sample
  task send(input int q [4]);
    int x, d;
    @(posedge mclk_i);
    for (int k = 0; k < NQTY; k++)
      qty_i[k] <= q[k][15:0];
    smp_valid_i <= 1'b1;
    for (int i = 0; i < NINST; i++)
    begin
      x = q[src_sel_i[i]];
      d = x - avg[i];
      avg[i] = (d < 0 ? -d : d) > int'(bypass_thr_i[i]) ? x : avg[i] + (d >>> 2);
      e[i] = quant(avg[i], int'(limit_i[i]));
    end
    @(posedge mclk_i);
    smp_valid_i <= 1'b0;
    repeat (1) @(posedge mclk_i);
    #1;
    for (int i = 0; i < NINST; i++)
      if (limit_i[i] == '0)
        chk(code_valid_o[i] && code_o[i] === 8'h00, "zero limit");
    repeat (8) @(posedge mclk_i);
    #1;
    for (int i = 0; i < NINST; i++)
      if (limit_i[i] != '0)
        chk(code_valid_o[i] && status_o[i] === e[i] &&
          (stall || code_o[i] === e[i]), "code word");
  endtask
  task t_clamp;
    send('{1500, -1, 126, -1});
    send('{3000, -3000, -200, 300});
    send('{-2, 2000, -127, 1});
  endtask
  task t_average;
    @(posedge mclk_i);
    bypass_thr_i <= {NINST{16'h0100}};
    send('{0, 0, 0, 0});
    send('{200, -200, 100, -100});
    send('{2000, -900, 0, 255});
  endtask
  task t_stall;
    @(posedge mclk_i);
    stall <= 1'b1;
    send('{500, -500, 50, -50});
    head = e;
    send('{-700, 700, -60, 60});
    chk(code_o === head, "head lost");
    @(posedge mclk_i);
    stall <= 1'b0;
    @(posedge mclk_i);
    #1;
    chk(code_valid_o === '1 && code_o === e, "spare word");
  endtask
  task t_zero;
    @(posedge mclk_i);
    limit_i[0] <= '0;
    send('{900, 1, 2, 3});
  endtask
  task test_done;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge mclk_i);
    srst_i <= 1'b0;
    t_clamp;
    t_average;
    t_stall;
    t_zero;
    test_done;
  end
endmodule
